// ---- logic/tprt_pkg.sv ----
// Purpose: constants for the test pattern, offset trim and margin registers
// Assumes: AHB-Lite slave, 32-bit data, one register per aligned word
// Notes: register offsets are word indices; byte address is four times
// Notes on behaviour
// - low pattern byte register, read/write, resets zero
// - middle pattern byte register, read/write, resets zero
// - high pattern nibble in bits 3-0
// - reserved upper bits read zero, ignore writes
// - reference select codes; 110b and 111b mean 5.0V
// - bit 5 enables margining, resets zero
// - signed 5-bit buffer offset code, bits 4-0
// - pattern used only while substitution selected; kept
// - output bits 21-2 carry pattern when selected
package tprt_pkg;
  // register word indices; byte address is four times the index
  localparam logic [7:0] TPRT_IDX_PAT_LOW = 8'h14;
  localparam logic [7:0] TPRT_IDX_PAT_MID = 8'h15;
  localparam logic [7:0] TPRT_IDX_PAT_HIGH = 8'h16;
  localparam logic [7:0] TPRT_IDX_CAL_SEL = 8'h20;
  localparam logic [7:0] TPRT_IDX_REF_MARGIN = 8'h30;
  // control register of our own: bit 0 selects pattern substitution
  localparam logic [7:0] TPRT_IDX_DATA_CTRL = 8'h10;
  localparam int TPRT_ADDR_W = 10;
  // writable-bit masks; other bits are reserved and read zero
  localparam logic [7:0] TPRT_MASK_PAT_LOW = 8'hff;
  localparam logic [7:0] TPRT_MASK_PAT_MID = 8'hff;
  localparam logic [7:0] TPRT_MASK_PAT_HIGH = 8'h0f;
  localparam logic [7:0] TPRT_MASK_CAL_SEL = 8'h07;
  localparam logic [7:0] TPRT_MASK_REF_MARGIN = 8'h3f;
  localparam logic [7:0] TPRT_MASK_DATA_CTRL = 8'h01;
  localparam logic [7:0] TPRT_RESET_VALUE = 8'h00;
  localparam int TPRT_MARGIN_EN_BIT = 5;
  localparam int TPRT_SUBST_BIT = 0;
  localparam int TPRT_PATTERN_W = 20;
  localparam int TPRT_WORD_W = 22;
  localparam int TPRT_WORD_LSB = 2;
  // reference ranges for offset calibration
  typedef enum logic [2:0] {
    TPRT_VREF_5V0,
    TPRT_VREF_4V5,
    TPRT_VREF_4V096,
    TPRT_VREF_3V3,
    TPRT_VREF_3V0,
    TPRT_VREF_2V5
  } tprt_vref_t;
endpackage

// ---- logic/tprt_word_mux.sv ----
// Purpose: choose conversion result or fixed pattern for the output word
// Assumes: parity bits 1-0 are supplied by the caller
// Notes: combinational; the top registers the result
module tprt_word_mux (
  input wire logic i_subst,
  input wire logic [tprt_pkg::TPRT_PATTERN_W-1:0] i_pattern,
  input wire logic [tprt_pkg::TPRT_PATTERN_W-1:0] i_conv,
  input wire logic [1:0] i_low_bits,
  output logic [tprt_pkg::TPRT_WORD_W-1:0] o_word
);
  import tprt_pkg::*;

  // pattern only replaces bits 21-2; the stored pattern is untouched
  assign o_word = {(i_subst ? i_pattern : i_conv), i_low_bits};
endmodule

// ---- logic/tprt_regs.sv ----
// Purpose: register bank for fixed output pattern, offset cal and margin
// Assumes: AHB-Lite single word transfers, zero wait states, OKAY only
// Notes: registers are 8 bits in the low byte lane; upper bits read zero
//
// Chosen here: register access over AHB-Lite.
module tprt_regs (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire logic [tprt_pkg::TPRT_PATTERN_W-1:0] i_conv_result,
  input wire logic [1:0] i_parity_bits,
  output logic [tprt_pkg::TPRT_WORD_W-1:0] o_output_word,
  output logic [tprt_pkg::TPRT_PATTERN_W-1:0] o_fixed_output_pattern,
  output logic o_pattern_substitute_select,
  output logic [2:0] o_reference_select,
  output logic o_margining_enable,
  output logic [4:0] o_buffer_offset_code
);
  import tprt_pkg::*;

  typedef struct packed {
    logic [7:0] pattern_low_byte;
    logic [7:0] pattern_middle_byte;
    logic [7:0] pattern_high_nibble;
    logic [7:0] offset_calibration_select;
    logic [7:0] reference_margin_control;
    logic [7:0] data_control;
    logic wr_pend;
    logic [7:0] wr_idx;
    logic [31:0] rdata;
    logic [TPRT_WORD_W-1:0] word;
    logic [2:0] ref_sel;
  } tprt_state_t;

  tprt_state_t state_reg;
  tprt_state_t state_next;
  logic [TPRT_WORD_W-1:0] word_mux;
  logic [TPRT_PATTERN_W-1:0] fixed_output_pattern;
  logic addr_phase;
  logic [7:0] addr_idx;

  // register index from a byte address; out-of-range bits force a miss
  function automatic logic [7:0] tprt_index(input logic [31:0] addr);
    if (addr[31:TPRT_ADDR_W] != '0) begin
      return 8'hff;
    end
    return addr[TPRT_ADDR_W-1:2];
  endfunction

  // read value of a register, reserved bits masked to zero
  function automatic logic [7:0] tprt_read(input tprt_state_t s,
                                           input logic [7:0] idx);
    case (idx)
      TPRT_IDX_PAT_LOW: return s.pattern_low_byte;
      TPRT_IDX_PAT_MID: return s.pattern_middle_byte;
      TPRT_IDX_PAT_HIGH: return s.pattern_high_nibble
                                & TPRT_MASK_PAT_HIGH;
      TPRT_IDX_CAL_SEL: return s.offset_calibration_select
                               & TPRT_MASK_CAL_SEL;
      TPRT_IDX_REF_MARGIN: return s.reference_margin_control
                                  & TPRT_MASK_REF_MARGIN;
      TPRT_IDX_DATA_CTRL: return s.data_control & TPRT_MASK_DATA_CTRL;
      default: return 8'h00;
    endcase
  endfunction

  // codes above the 2.5V entry fall back to the 5.0V calibration
  function automatic logic [2:0] tprt_ref_decode(input logic [2:0] code);
    if (code > 3'(TPRT_VREF_2V5)) begin
      return 3'(TPRT_VREF_5V0);
    end
    return code;
  endfunction

  // pattern assembled high nibble, middle byte, low byte
  assign fixed_output_pattern = {state_reg.pattern_high_nibble[3:0],
                                 state_reg.pattern_middle_byte,
                                 state_reg.pattern_low_byte};

  assign addr_phase = i_hsel & i_hready & i_htrans[1];
  assign addr_idx = tprt_index(i_haddr);

  tprt_word_mux u_mux (
    .i_subst(state_reg.data_control[TPRT_SUBST_BIT]),
    .i_pattern(fixed_output_pattern),
    .i_conv(i_conv_result),
    .i_low_bits(i_parity_bits),
    .o_word(word_mux)
  );

  // next state: write data lands in the data phase after the address phase
  always_comb begin
    state_next = state_reg;
    state_next.word = word_mux;
    if (state_reg.wr_pend) begin
      case (state_reg.wr_idx)
        TPRT_IDX_PAT_LOW: state_next.pattern_low_byte =
          i_hwdata[7:0] & TPRT_MASK_PAT_LOW;
        TPRT_IDX_PAT_MID: state_next.pattern_middle_byte =
          i_hwdata[7:0] & TPRT_MASK_PAT_MID;
        TPRT_IDX_PAT_HIGH: state_next.pattern_high_nibble =
          i_hwdata[7:0] & TPRT_MASK_PAT_HIGH;
        TPRT_IDX_CAL_SEL: state_next.offset_calibration_select =
          i_hwdata[7:0] & TPRT_MASK_CAL_SEL;
        TPRT_IDX_REF_MARGIN: state_next.reference_margin_control =
          i_hwdata[7:0] & TPRT_MASK_REF_MARGIN;
        TPRT_IDX_DATA_CTRL: state_next.data_control =
          i_hwdata[7:0] & TPRT_MASK_DATA_CTRL;
        default: ;
      endcase
    end
    // decode kept in a flop so the select output has no logic behind it
    state_next.ref_sel =
      tprt_ref_decode(state_next.offset_calibration_select[2:0]);
    state_next.wr_pend = addr_phase & i_hwrite;
    state_next.wr_idx = addr_idx;
    // read data captured at the address phase, so a read right after a
    // write to the same register returns the old value
    if (addr_phase & ~i_hwrite) begin
      state_next.rdata = {24'h000000, tprt_read(state_reg, addr_idx)};
    end else begin
      state_next.rdata = 32'h00000000;
    end
  end

  // all state in one register; synchronous reset to zero
  always_ff @(posedge i_mclk) begin
    if (i_srst) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs straight from flip-flops
  assign o_hrdata = state_reg.rdata;
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;
  assign o_output_word = state_reg.word;
  assign o_fixed_output_pattern = {state_reg.pattern_high_nibble[3:0],
                                   state_reg.pattern_middle_byte,
                                   state_reg.pattern_low_byte};
  assign o_pattern_substitute_select = state_reg.data_control[TPRT_SUBST_BIT];
  // decoded select; raw codes 6 and 7 still read back as written
  assign o_reference_select = state_reg.ref_sel;
  assign o_margining_enable =
    state_reg.reference_margin_control[TPRT_MARGIN_EN_BIT];
  assign o_buffer_offset_code =
    state_reg.reference_margin_control[4:0];
endmodule

// ---- tb/tprt_regs_properties.sv ----
// Purpose: port checks for the pattern and trim register bank
// Assumes: zero-wait slave, data phase one cycle after the address
// Notes: byte address is four times the register index
module tprt_chk (
  input wire logic i_mclk,
  input wire logic i_srst,
  input wire logic i_hsel,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] i_haddr,
  input wire logic [31:0] i_hwdata,
  input wire logic [31:0] o_hrdata,
  input wire logic [1:0] i_htrans,
  input wire logic [1:0] i_parity_bits,
  input wire logic o_pattern_substitute_select,
  input wire logic o_margining_enable,
  input wire logic [19:0] i_conv_result,
  input wire logic [19:0] o_fixed_output_pattern,
  input wire logic [21:0] o_output_word,
  input wire logic [2:0] o_reference_select,
  input wire logic [4:0] o_buffer_offset_code
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_srst);
  // a transfer is taken on a nonseq or seq address phase
  wire logic go = i_hsel && i_hready && i_htrans[1];
  sequence wr(a); go && i_hwrite && i_haddr == a; endsequence
  sequence rd(a); go && !i_hwrite && i_haddr == a; endsequence
  a_rdata_idle: assert property (!(go && !i_hwrite) |=> o_hrdata == 0)
    else $error("read data outside a read data phase");
  a_high_rsvd: assert property (rd(32'h58) |=> o_hrdata[31:4] == 0)
    else $error("pattern high reserved bits not zero");
  a_cal_rsvd: assert property (rd(32'h80) |=> o_hrdata[31:3] == 0)
    else $error("calibration reserved bits not zero");
  a_low_write: assert property (wr(32'h50) |-> ##2
    o_fixed_output_pattern[7:0] == $past(i_hwdata[7:0]))
    else $error("low pattern byte not written");
  a_mid_write: assert property (wr(32'h54) ##1 1 |=>
    o_fixed_output_pattern[15:8] == $past(i_hwdata[7:0]))
    else $error("middle pattern byte not written");
  a_margin_write: assert property (wr(32'hc0) |-> ##2
    {o_margining_enable, o_buffer_offset_code} == $past(i_hwdata[5:0]))
    else $error("margin control not written");
  a_ref_write: assert property (wr(32'h80) |-> ##2 o_reference_select ==
    ($past(i_hwdata[2:0]) > 3'h5 ? 3'h0 : $past(i_hwdata[2:0])))
    else $error("reference select wrong");
  a_word_mux: assert property (!$past(i_srst) |->
    o_output_word == {$past(o_pattern_substitute_select) ?
    $past(o_fixed_output_pattern) : $past(i_conv_result),
    $past(i_parity_bits)})
    else $error("output word source wrong");
endmodule
bind tprt_regs tprt_chk i_tprt_chk (
  .i_mclk(i_mclk),
  .i_srst(i_srst),
  .i_hsel(i_hsel),
  .i_hwrite(i_hwrite),
  .i_hready(i_hready),
  .i_haddr(i_haddr),
  .i_hwdata(i_hwdata),
  .o_hrdata(o_hrdata),
  .i_htrans(i_htrans),
  .i_parity_bits(i_parity_bits),
  .o_pattern_substitute_select(o_pattern_substitute_select),
  .o_margining_enable(o_margining_enable),
  .i_conv_result(i_conv_result),
  .o_fixed_output_pattern(o_fixed_output_pattern),
  .o_output_word(o_output_word),
  .o_reference_select(o_reference_select),
  .o_buffer_offset_code(o_buffer_offset_code)
);

// ---- tb/tb_top.sv ----
// Purpose: self-checking bench for the pattern and trim register bank
// Assumes: zero-wait slave; substitution bit lives in the word at 40h
// Notes: each scenario is its own task
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin \
  error_cnt++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, hsel = 0, hw = 0, rdy, resp, sub, men;
  logic [1:0] htr = 0, par = 2'h2;
  logic [31:0] ha = 0, hwd = 0, hrd, q;
  logic [19:0] conv = 20'h12345, pat;
  logic [21:0] word;
  logic [2:0] rsel;
  logic [4:0] boc;
  int error_cnt = 0, checked = 0;
  logic [31:0] adr [6] = '{32'h50, 32'h54, 32'h58, 32'h80, 32'hc0, 32'h400};
  logic [7:0] msk [6] = '{8'hff, 8'hff, 8'h0f, 8'h07, 8'h3f, 8'h00};
  tprt_regs i_tprt_regs (.i_mclk(clk), .i_srst(rst), .i_hsel(hsel),
    .i_haddr(ha), .i_htrans(htr), .i_hwrite(hw), .i_hsize(3'h2),
    .i_hwdata(hwd), .i_hready(rdy), .o_hrdata(hrd), .o_hreadyout(rdy),
    .o_hresp(resp), .i_conv_result(conv), .i_parity_bits(par),
    .o_output_word(word), .o_fixed_output_pattern(pat),
    .o_pattern_substitute_select(sub), .o_reference_select(rsel),
    .o_margining_enable(men), .o_buffer_offset_code(boc));
  initial forever #20 clk = ~clk;
  // one single transfer; settle to the falling edge so outputs are stable
  task automatic xfer(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    {hsel, htr, hw, ha} <= {1'b1, 2'h2, w, a};
    do @(posedge clk); while (rdy !== 1'b1);
    {hsel, htr, hwd} <= {1'b0, 2'h0, d};
    do @(posedge clk); while (rdy !== 1'b1);
    q = hrd;
    `CHK("resp", 1'b0, resp)
    @(negedge clk);
  endtask
  task automatic rdc(input logic [31:0] a, e);
    xfer(0, a, 0);
    `CHK("read", e, q)
  endtask
  task t_reset;
    foreach (adr[i]) rdc(adr[i], 0);
  endtask
  // all ones shows which bits hold and which stay reserved
  task t_masks;
    foreach (adr[i]) begin
      xfer(1, adr[i], 32'hffff_ffff);
      rdc(adr[i], {24'h0, msk[i]});
    end
  endtask
  task t_ref;
    for (int c = 0; c < 8; c++) begin
      xfer(1, 32'h80, c);
      `CHK("refsel", (c > 5) ? 3'h0 : 3'(c), rsel)
    end
  endtask
  task t_margin;
    xfer(1, 32'hc0, 32'h30);
    `CHK("marg", 6'h30, {men, boc})
    xfer(1, 32'hc0, 32'h0f);
    `CHK("marg", 6'h0f, {men, boc})
  endtask
  // word is registered one cycle behind the select, hence the extra wait
  task t_subst;
    xfer(1, 32'h50, 32'ha5);
    xfer(1, 32'h54, 32'h3c);
    xfer(1, 32'h58, 32'h9);
    `CHK("pat", 20'h93ca5, pat)
    `CHK("conv", {conv, par}, word)
    xfer(1, 32'h40, 1);
    `CHK("sel", 1'b1, sub)
    @(negedge clk);
    `CHK("subst", {20'h93ca5, par}, word)
    xfer(1, 32'h40, 0);
    `CHK("sel", 1'b0, sub)
    @(negedge clk);
    `CHK("kept", 20'h93ca5, pat)
    `CHK("back", {conv, par}, word)
  endtask
  task close_out;
    $display("checks %0d errors %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    #200us;
    error_cnt++;
    close_out;
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 0;
    t_reset;
    t_masks;
    t_ref;
    t_margin;
    t_subst;
    close_out;
  end
endmodule
